// ### dpm_mode_select.sv
// Purpose: Latch operating mode from test reset and emulation pins; debug halt control
// Assumes: Pins asynchronous to REF_CLK; power-up seen as release of ARST_N
// Notes:   Mode encoding and pin pulse length are internal choices
// Function
// - Mode chosen from test reset and both emulation pins at power-up.
// - Selected mode applies right away, no further event needed.
// - Each rising edge of test reset samples pins and latches mode.
// - All low gives peripheral-slave mode, core off, cable inactive.
// - Emulation pin b high, a low: held in reset until released.
// - Both emulation pins high: normal run, emulation disabled.
// - Test reset high: normal run, emulation enabled, cable active.
// - Debug-halt stops background code.
// - Time-critical interrupts still served while background is halted in realtime mode.
// - Debug event may halt device or pulse either emulation pin.
// - Break event moves device into debug-halt.
// - Stop mode halted: all interrupts including reset ignored until run.
`timescale 1ns/1ns
`default_nettype none
module dpm_mode_select (
  input  wire logic REF_CLK,
  input  wire logic ARST_N,
  input  wire logic TRST_PIN,
  input  wire logic EMU_A_IN,
  input  wire logic EMU_B_IN,
  input  wire logic TCK_IN,
  input  wire logic REALTIME_MODE,
  input  wire logic SW_BREAK,
  input  wire logic WATCH_MATCH,
  input  wire logic HOST_REQ,
  input  wire logic EVENT_IS_BREAK,
  input  wire logic PULSE_A_EN,
  input  wire logic PULSE_B_EN,
  input  wire logic RUN_CMD,
  input  wire logic STEP_CMD,
  input  wire logic STEP_DONE,
  input  wire logic EXT_RELEASE,
  input  wire logic TC_INT_REQ,
  input  wire logic INT_REQ,
  output logic      CORE_ENABLE,
  output logic      CORE_RESET_HOLD,
  output logic      CABLE_ACTIVE,
  output logic      EMU_ENABLED,
  output logic      BG_HALT,
  output logic      INT_ALLOW,
  output logic      TC_INT_ALLOW,
  output logic      EMU_A_OUT,
  output logic      EMU_A_OE,
  output logic      EMU_B_OUT,
  output logic      EMU_B_OE,
  output logic      TEST_CLOCK_RETURN
);

  // Three-stage synchronisers
  logic [2:0] trst_sync_reg, emu_a_sync_reg, emu_b_sync_reg, tck_sync_reg;
  logic [2:0] trst_sync_next, emu_a_sync_next, emu_b_sync_next, tck_sync_next;
  dpm_pkg::dpm_pins_s pins_reg, pins_next;
  logic               tck_reg, tck_next;

  always_comb begin
    trst_sync_next  = {trst_sync_reg[1:0], TRST_PIN};
    emu_a_sync_next = {emu_a_sync_reg[1:0], EMU_A_IN};
    emu_b_sync_next = {emu_b_sync_reg[1:0], EMU_B_IN};
    tck_sync_next   = {tck_sync_reg[1:0], TCK_IN};
    pins_next = pins_reg;
    tck_next  = tck_reg;
    // A change counts once stages two and three agree
    if (trst_sync_reg[1] == trst_sync_reg[2]) begin
      pins_next.trst = trst_sync_reg[2];
    end
    if (emu_a_sync_reg[1] == emu_a_sync_reg[2]) begin
      pins_next.emu_a = emu_a_sync_reg[2];
    end
    if (emu_b_sync_reg[1] == emu_b_sync_reg[2]) begin
      pins_next.emu_b = emu_b_sync_reg[2];
    end
    if (tck_sync_reg[1] == tck_sync_reg[2]) begin
      tck_next = tck_sync_reg[2];
    end
  end

  // Decode a pin combination into a mode
  function automatic dpm_pkg::dpm_mode_e decode_mode(input dpm_pkg::dpm_pins_s p);
    if (p.trst) begin
      decode_mode = dpm_pkg::DPM_MODE_EMU;
    end else begin
      unique case ({p.emu_b, p.emu_a})
        2'h0:    decode_mode = dpm_pkg::DPM_MODE_SLAVE;
        2'h1:    decode_mode = dpm_pkg::DPM_MODE_TESTRSV;
        2'h2:    decode_mode = dpm_pkg::DPM_MODE_WAITRST;
        2'h3:    decode_mode = dpm_pkg::DPM_MODE_NORMAL;
      endcase
    end
  endfunction

  // Power-up latch waits one edge past the synchroniser, so pins_reg holds real levels
  logic [2:0]          settle_reg, settle_next;
  logic                latched_reg, latched_next;
  dpm_pkg::dpm_mode_e  mode_reg, mode_next;
  logic                trst_prev_reg, trst_prev_next;
  logic                trst_rise;
  logic                wait_rel_reg, wait_rel_next;

  assign trst_rise = pins_reg.trst && !trst_prev_reg;

  always_comb begin
    settle_next    = (settle_reg == dpm_pkg::DPM_SETTLE_CYC) ? settle_reg : settle_reg + 3'h1;
    latched_next   = latched_reg;
    mode_next      = mode_reg;
    trst_prev_next = pins_reg.trst;
    // release ends held reset; a latch in the same cycle wins
    wait_rel_next  = EXT_RELEASE ? 1'b0 : wait_rel_reg;
    if (!latched_reg && settle_reg == dpm_pkg::DPM_SETTLE_CYC) begin
      latched_next  = 1'b1;
      mode_next     = decode_mode(pins_reg);
      wait_rel_next = 1'b1;
    end else if (latched_reg && trst_rise) begin
      mode_next     = decode_mode(pins_reg);
      wait_rel_next = 1'b1;
    end
  end

  // Execution state
  dpm_pkg::dpm_exec_e exec_reg, exec_next;
  dpm_pkg::dpm_event_s ev;
  logic                any_event, brk;

  always_comb begin
    ev.sw_break    = SW_BREAK;
    ev.watch_match = WATCH_MATCH;
    ev.host_req    = HOST_REQ;
    any_event = |ev;
    brk       = any_event && EVENT_IS_BREAK && EMU_ENABLED;
    exec_next = exec_reg;
    unique case (exec_reg)
      dpm_pkg::DPM_EXEC_RUN: begin
        if (brk) begin
          exec_next = dpm_pkg::DPM_EXEC_HALT;
        end
      end
      dpm_pkg::DPM_EXEC_HALT: begin
        if (RUN_CMD) begin
          exec_next = dpm_pkg::DPM_EXEC_RUN;
        end else if (STEP_CMD) begin
          exec_next = dpm_pkg::DPM_EXEC_STEP;
        end
      end
      dpm_pkg::DPM_EXEC_STEP: begin
        if (STEP_DONE || brk) begin
          exec_next = dpm_pkg::DPM_EXEC_HALT;
        end
      end
      default: exec_next = dpm_pkg::DPM_EXEC_RUN;
    endcase
  end

  // emulation pin pulses on debug events
  logic [3:0] pulse_a_reg, pulse_a_next, pulse_b_reg, pulse_b_next;

  always_comb begin
    pulse_a_next = (pulse_a_reg != dpm_pkg::DPM_PULSE_RESET) ? pulse_a_reg - 4'h1 : pulse_a_reg;
    pulse_b_next = (pulse_b_reg != dpm_pkg::DPM_PULSE_RESET) ? pulse_b_reg - 4'h1 : pulse_b_reg;
    if (any_event && PULSE_A_EN && CABLE_ACTIVE) begin
      pulse_a_next = dpm_pkg::DPM_PULSE_CYC;
    end
    if (any_event && PULSE_B_EN && CABLE_ACTIVE) begin
      pulse_b_next = dpm_pkg::DPM_PULSE_CYC;
    end
  end

  // Output decode
  logic core_en_n, rst_hold_n, cable_n, emu_en_n, halt_n, int_n, tc_n;

  always_comb begin
    core_en_n  = (mode_reg != dpm_pkg::DPM_MODE_SLAVE) && latched_reg;
    rst_hold_n = !latched_reg || (mode_reg == dpm_pkg::DPM_MODE_WAITRST && wait_rel_next);
    cable_n    = latched_reg && (mode_reg == dpm_pkg::DPM_MODE_EMU ||
                                 mode_reg == dpm_pkg::DPM_MODE_WAITRST);
    // emulation only with test reset high
    emu_en_n   = latched_reg && mode_reg == dpm_pkg::DPM_MODE_EMU;
    halt_n     = exec_next == dpm_pkg::DPM_EXEC_HALT;
    int_n      = !halt_n && INT_REQ;
    // realtime halt still serves time-critical work
    tc_n       = (!halt_n || REALTIME_MODE) && TC_INT_REQ;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trst_sync_reg     <= dpm_pkg::DPM_SYNC_RESET;
      emu_a_sync_reg    <= dpm_pkg::DPM_SYNC_RESET;
      emu_b_sync_reg    <= dpm_pkg::DPM_SYNC_RESET;
      tck_sync_reg      <= dpm_pkg::DPM_SYNC_RESET;
      pins_reg          <= '0;
      tck_reg           <= 1'b0;
      settle_reg        <= 3'h0;
      latched_reg       <= 1'b0;
      mode_reg          <= dpm_pkg::DPM_MODE_NORMAL;
      trst_prev_reg     <= 1'b0;
      wait_rel_reg      <= 1'b0;
      exec_reg          <= dpm_pkg::DPM_EXEC_RUN;
      pulse_a_reg       <= dpm_pkg::DPM_PULSE_RESET;
      pulse_b_reg       <= dpm_pkg::DPM_PULSE_RESET;
      CORE_ENABLE       <= 1'b0;
      CORE_RESET_HOLD   <= 1'b1;
      CABLE_ACTIVE      <= 1'b0;
      EMU_ENABLED       <= 1'b0;
      BG_HALT           <= 1'b0;
      INT_ALLOW         <= 1'b0;
      TC_INT_ALLOW      <= 1'b0;
      EMU_A_OUT         <= 1'b0;
      EMU_A_OE          <= 1'b0;
      EMU_B_OUT         <= 1'b0;
      EMU_B_OE          <= 1'b0;
      TEST_CLOCK_RETURN <= 1'b0;
    end else begin
      trst_sync_reg     <= trst_sync_next;
      emu_a_sync_reg    <= emu_a_sync_next;
      emu_b_sync_reg    <= emu_b_sync_next;
      tck_sync_reg      <= tck_sync_next;
      pins_reg          <= pins_next;
      tck_reg           <= tck_next;
      settle_reg        <= settle_next;
      latched_reg       <= latched_next;
      mode_reg          <= mode_next;
      trst_prev_reg     <= trst_prev_next;
      wait_rel_reg      <= wait_rel_next;
      exec_reg          <= exec_next;
      pulse_a_reg       <= pulse_a_next;
      pulse_b_reg       <= pulse_b_next;
      CORE_ENABLE       <= core_en_n;
      CORE_RESET_HOLD   <= rst_hold_n;
      CABLE_ACTIVE      <= cable_n;
      EMU_ENABLED       <= emu_en_n;
      BG_HALT           <= halt_n;
      INT_ALLOW         <= int_n;
      TC_INT_ALLOW      <= tc_n;
      // Drive low only while pulsing; pins otherwise released
      EMU_A_OUT         <= 1'b0;
      EMU_A_OE          <= pulse_a_next != dpm_pkg::DPM_PULSE_RESET;
      EMU_B_OUT         <= 1'b0;
      EMU_B_OE          <= pulse_b_next != dpm_pkg::DPM_PULSE_RESET;
      // returned test clock, delayed by the sampler
      TEST_CLOCK_RETURN <= tck_reg;
    end
  end

  // mode moves only at latch events
  chk_mode_holds: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && !$past(trst_rise) && $past(latched_reg) |-> $stable(mode_reg))
    else $error("mode changed without latch event");
  chk_trst_latch: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && trst_rise |=> mode_reg == dpm_pkg::DPM_MODE_EMU)
    else $error("test reset rise did not latch mode");
  chk_slave_off: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && mode_reg == dpm_pkg::DPM_MODE_SLAVE |=> !CORE_ENABLE && !CABLE_ACTIVE)
    else $error("slave mode left core enabled");
  chk_wait_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && mode_reg == dpm_pkg::DPM_MODE_WAITRST && wait_rel_reg && !EXT_RELEASE
    |=> CORE_RESET_HOLD && CABLE_ACTIVE)
    else $error("held reset released early");
  chk_normal_run: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && mode_reg == dpm_pkg::DPM_MODE_NORMAL |=> !EMU_ENABLED && CORE_ENABLE)
    else $error("normal mode wrong");
  chk_emu_mode: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    latched_reg && mode_reg == dpm_pkg::DPM_MODE_EMU |=> EMU_ENABLED && CABLE_ACTIVE)
    else $error("emulation mode wrong");
  chk_boot_latch: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $rose(latched_reg) |-> mode_reg == decode_mode($past(pins_reg)))
    else $error("power-up mode not from pins");
  chk_boot_time: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !latched_reg |-> ##[0:5] latched_reg)
    else $error("mode not applied promptly");
  chk_break_halt: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    exec_reg == dpm_pkg::DPM_EXEC_RUN && brk |=> BG_HALT)
    else $error("break did not halt");
  chk_stop_noint: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    BG_HALT && !$past(REALTIME_MODE) |-> !INT_ALLOW && !TC_INT_ALLOW)
    else $error("interrupt taken in stop halt");
  chk_tc_serve: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    REALTIME_MODE && TC_INT_REQ |=> TC_INT_ALLOW)
    else $error("time-critical interrupt blocked");
  chk_pulse_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $rose(EMU_A_OE) |-> EMU_A_OE [*4])
    else $error("pin pulse too short");

  cov_halt: cover property (@(posedge REF_CLK) disable iff (!ARST_N) $rose(BG_HALT));
  cov_relatch: cover property (@(posedge REF_CLK) disable iff (!ARST_N) latched_reg && trst_rise);
  cov_waitrel: cover property (@(posedge REF_CLK) disable iff (!ARST_N) $fell(CORE_RESET_HOLD));

endmodule
`default_nettype wire

// ### dpm_pkg.sv
// Purpose: Shared types and constants for the debug-port mode selector
// Assumes: 100 MHz REF_CLK, pins sampled through three flip-flops
// Notes:   Mode encoding is internal only
package dpm_pkg;

  typedef enum logic [2:0] {
    DPM_MODE_SLAVE,
    DPM_MODE_TESTRSV,
    DPM_MODE_WAITRST,
    DPM_MODE_NORMAL,
    DPM_MODE_EMU
  } dpm_mode_e;

  typedef enum logic [1:0] {
    DPM_EXEC_RUN,
    DPM_EXEC_HALT,
    DPM_EXEC_STEP
  } dpm_exec_e;

  // Synchronised pin levels
  typedef struct packed {
    logic trst;
    logic emu_b;
    logic emu_a;
  } dpm_pins_s;

  // Debug event sources
  typedef struct packed {
    logic sw_break;
    logic watch_match;
    logic host_req;
  } dpm_event_s;

  localparam logic [2:0] DPM_SYNC_RESET  = 3'h0;
  localparam logic [2:0] DPM_SETTLE_CYC  = 3'h4;
  localparam int         DPM_PULSE_NS    = 40;
  localparam int         DPM_CLK_NS      = 10;
  localparam logic [3:0] DPM_PULSE_CYC   = 4'(DPM_PULSE_NS / DPM_CLK_NS);
  localparam logic [3:0] DPM_PULSE_RESET = 4'h0;

endpackage

// ### dpm_emu_model.sv
// Purpose: Emulator pod and target board model facing the mode selector
// Assumes: Pull-ups on both emulation pins, test reset driven by the pod
// Notes:   Test clock stands still outside frames
`timescale 1ns/1ns
`default_nettype none
module dpm_emu_model (
  input  wire logic tck_run,
  input  wire logic trst_drv,
  input  wire logic ext_a_low,
  input  wire logic ext_b_low,
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  output logic      trst,
  output logic      tck,
  output logic      emu_a,
  output logic      emu_b
);
  assign trst = trst_drv;

  initial begin
    tck = 1'b0;
    #7;
    forever begin
      #40;
      tck = tck_run ? ~tck : 1'b0;
    end
  end

  // Pull-up wins unless a party drives low
  assign emu_a = ext_a_low ? 1'b0 : (a_oe ? a_out : 1'b1);
  assign emu_b = ext_b_low ? 1'b0 : (b_oe ? b_out : 1'b1);
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the debug-port mode selector
// Assumes: Power-up modelled by releasing ARST_N
// Notes:   Status vector packs mode, halt and interrupt gates
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk, arst_n, tck_run, trst_drv, ext_a, ext_b;
  logic rt_mode, is_brk, pa_en, pb_en, run_cmd, step_cmd, step_done, ext_rel;
  logic int_req, tc_req;
  dpm_pkg::dpm_event_s ev;
  wire logic core_en, rst_hold, cable, emu_en, bg_halt, int_ok, tc_ok;
  wire logic a_out, a_oe, b_out, b_oe, test_clock_return, trst, tck, emu_a, emu_b;
  wire logic [7:0] st;
  int error_cnt;
  int checked;

  assign st = {core_en, rst_hold, cable, emu_en, bg_halt, int_ok, tc_ok, 1'b0};

  dpm_mode_select i_dpm_mode_select (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .TRST_PIN(trst), .EMU_A_IN(emu_a),
    .EMU_B_IN(emu_b), .TCK_IN(tck), .REALTIME_MODE(rt_mode), .SW_BREAK(ev.sw_break),
    .WATCH_MATCH(ev.watch_match), .HOST_REQ(ev.host_req), .EVENT_IS_BREAK(is_brk),
    .PULSE_A_EN(pa_en), .PULSE_B_EN(pb_en), .RUN_CMD(run_cmd), .STEP_CMD(step_cmd),
    .STEP_DONE(step_done), .EXT_RELEASE(ext_rel), .TC_INT_REQ(tc_req), .INT_REQ(int_req),
    .CORE_ENABLE(core_en), .CORE_RESET_HOLD(rst_hold), .CABLE_ACTIVE(cable),
    .EMU_ENABLED(emu_en), .BG_HALT(bg_halt), .INT_ALLOW(int_ok), .TC_INT_ALLOW(tc_ok),
    .EMU_A_OUT(a_out), .EMU_A_OE(a_oe), .EMU_B_OUT(b_out), .EMU_B_OE(b_oe),
    .TEST_CLOCK_RETURN(test_clock_return)
  );

  dpm_emu_model i_dpm_emu_model (
    .tck_run(tck_run), .trst_drv(trst_drv), .ext_a_low(ext_a), .ext_b_low(ext_b),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .trst(trst), .tck(tck), .emu_a(emu_a), .emu_b(emu_b)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait; a stuck design ends the run
  task automatic wait_st(input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    while ((st & m) !== e && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    cmp(st & m, e);
    if (n >= 20) report_and_stop();
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask

  task automatic powerup(input logic al, input logic bl, input logic [7:0] m,
                         input logic [7:0] e);
    @(negedge ref_clk);
    arst_n = 1'b0;
    // pod keeps test reset low through power-up
    trst_drv = 1'b0;
    ext_a = al;
    ext_b = bl;
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    wait_st(m, e);
  endtask

  // One break event from source src; on says emulation is enabled
  task automatic brk(input int src, input logic rt, input logic on);
    logic pa;
    logic pb;
    logic [7:0] exp_pins;
    pa = (src != 1);
    pb = (src != 0);
    @(negedge ref_clk);
    rt_mode = rt;
    ev = 3'h0;
    ev[src] = 1'b1;
    is_brk = 1'b1;
    pa_en = pa;
    pb_en = pb;
    @(negedge ref_clk);
    ev = 3'h0;
    is_brk = 1'b0;
    @(negedge ref_clk);
    // Pulsed pin must read low at the header
    exp_pins = {on, on & pa, on & pb, ~(on & pa), ~(on & pb), 3'h0};
    cmp({bg_halt, a_oe, b_oe, emu_a, emu_b, 3'h0}, exp_pins);
    if (on) begin
      cmp({6'h0, int_ok, tc_ok}, {7'h0, rt});
      repeat (2) @(negedge ref_clk);
      cmp({6'h0, a_oe, b_oe}, {6'h0, pa, pb});
      @(negedge ref_clk);
      cmp({6'h0, a_oe, b_oe}, 8'h00);
      pulse(run_cmd);
      wait_st(8'h0e, 8'h06);
    end
  endtask

  task automatic tck_echo();
    int n;
    logic last;
    n = 0;
    tck_run = 1'b1;
    last = test_clock_return;
    repeat (100) begin
      @(negedge ref_clk);
      if (test_clock_return !== last) n++;
      last = test_clock_return;
    end
    tck_run = 1'b0;
    cmp({7'h0, n >= 10}, 8'h01);
  endtask

  task automatic emu_latch();
    @(negedge ref_clk);
    trst_drv = 1'b1;
    wait_st(8'hf0, 8'hb0);
    ext_a = 1'b1;
    ext_b = 1'b1;
    repeat (10) @(negedge ref_clk);
    cmp(st & 8'hf0, 8'hb0);
    ext_a = 1'b0;
    ext_b = 1'b0;
  endtask

  // Break, single step, step done, run
  task automatic step_run();
    @(negedge ref_clk);
    is_brk = 1'b1;
    ev.sw_break = 1'b1;
    @(negedge ref_clk);
    ev = 3'h0;
    is_brk = 1'b0;
    wait_st(8'h08, 8'h08);
    pulse(step_cmd);
    wait_st(8'h08, 8'h00);
    pulse(step_done);
    wait_st(8'h08, 8'h08);
    pulse(run_cmd);
    wait_st(8'h08, 8'h00);
  endtask

  // Requests gate the allow outputs while running
  task automatic irq_gate();
    @(negedge ref_clk);
    int_req = 1'b0;
    tc_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp({6'h0, int_ok, tc_ok}, 8'h00);
    int_req = 1'b1;
    tc_req = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp({6'h0, int_ok, tc_ok}, 8'h03);
  endtask

  initial begin
    {ref_clk, arst_n, tck_run, trst_drv, ext_a, ext_b} = 6'h0;
    {rt_mode, is_brk, pa_en, pb_en, run_cmd, step_cmd, step_done, ext_rel} = 8'h0;
    {int_req, tc_req} = 2'h3;
    ev = 3'h0;
    error_cnt = 0;
    checked = 0;
    powerup(1'b0, 1'b0, 8'hf0, 8'h80);
    brk(0, 1'b0, 1'b0);
    tck_echo();
    emu_latch();
    for (int s = 0; s < 3; s++) begin
      brk(s, 1'b0, 1'b1);
    end
    brk(2, 1'b1, 1'b1);
    brk(0, 1'b0, 1'b1);
    step_run();
    irq_gate();
    powerup(1'b0, 1'b1, 8'hf0, 8'h80);
    powerup(1'b1, 1'b1, 8'he0, 8'h00);
    ext_a = 1'b1;
    emu_latch();
    // Pin a held low only until the mode has latched
    powerup(1'b1, 1'b0, 8'h70, 8'h60);
    ext_a = 1'b0;
    repeat (10) @(negedge ref_clk);
    cmp(st & 8'h70, 8'h60);
    pulse(ext_rel);
    wait_st(8'h40, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
